// *** shared/disp_pkg.sv ***
// Shared constants, types and state encodings for the serial display port
package disp_pkg;

    // ------------------------------------------------------------------
    // Frame geometry
    // ------------------------------------------------------------------
    localparam int unsigned FRAME_BYTES = 172800;
    localparam int unsigned PIXEL_BITS  = 18;
    localparam int unsigned PIXELS      = FRAME_BYTES * 8 / PIXEL_BITS;
    localparam int unsigned COLS        = 240;
    localparam int unsigned COL_W       = 8;
    localparam int unsigned ROW_W       = 9;
    localparam int unsigned ADDR_W      = 17;
    localparam logic [COL_W-1:0] COL_LAST = 8'hEF;
    localparam logic [ROW_W-1:0] ROW_LAST = 9'h13F;

    // ------------------------------------------------------------------
    // Serial framing
    // ------------------------------------------------------------------
    localparam logic [2:0] BIT_LAST   = 3'h7;
    localparam logic [3:0] RD_BIT_LAST = 4'hF;

    // Command bytes (sent with the select line low)
    localparam logic [7:0] CMD_SET_COLUMN = 8'h01;
    localparam logic [7:0] CMD_SET_ROW    = 8'h02;
    localparam logic [7:0] CMD_MEM_WRITE  = 8'h03;
    localparam logic [7:0] CMD_MEM_READ   = 8'h04;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_POSITION  = 8'h08;
    localparam logic [7:0] REG_LAST_CMD  = 8'h0C;
    localparam logic [7:0] REG_PIX_COUNT = 8'h10;
    localparam int unsigned CTRL_COL_DOWN = 0;
    localparam int unsigned CTRL_ROW_DOWN = 1;
    localparam logic [1:0]  CTRL_RESET    = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_COLUMN = 3'h1,
        ST_ROW    = 3'h3,
        ST_WRITE  = 3'h2,
        ST_READ   = 3'h6
    } link_state_e;

    typedef struct packed {
        logic display_reset_n;
        logic backlight_on;
        logic chip_select_n;
        logic data_command_sel;
        logic write_data_in;
        logic serial_clk;
    } pin_in_s;

    // Idle levels: reset released, deselected
    localparam logic [5:0] PIN_RESET = 6'h28;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic                  we;
        logic [ADDR_W-1:0]     addr;
        logic [PIXEL_BITS-1:0] data;
    } pix_wr_s;

endpackage

// *** logic/pin_sync.sv ***
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ps

module pin_sync #(
    parameter int unsigned         WIDTH     = 1,
    parameter logic [WIDTH-1:0]    RESET_VAL = '0
) (
    // System
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // Pins
    input  wire logic [WIDTH-1:0]  d_i,
    output logic      [WIDTH-1:0]  q_o
);

    logic [WIDTH-1:0] meta;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                meta[i] <= RESET_VAL[i];
                q_o[i]  <= RESET_VAL[i];
            end else if (ce_i) begin
                meta[i] <= d_i[i];
                q_o[i]  <= meta[i];
            end
        end
    end

endmodule // pin_sync

// *** logic/frame_store.sv ***
// Graphics frame memory, one write port and one registered read port
`timescale 1ns/1ps

module frame_store
    import disp_pkg::*;
(
    // System
    input  wire logic                   clk_i,
    input  wire logic                   ce_i,
    // Ports
    input  wire pix_wr_s                wr_i,
    input  wire logic [ADDR_W-1:0]      rd_addr_i,
    output logic      [PIXEL_BITS-1:0]  rd_data_o
);

    logic [PIXEL_BITS-1:0] mem [PIXELS];

    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (wr_i.we) begin
                mem[wr_i.addr] <= wr_i.data;
            end
            rd_data_o <= mem[rd_addr_i];
        end
    end

endmodule // frame_store

// *** logic/serial_display_write_port.sv ***
// Serial display port: byte receiver, pixel addressing, frame memory, registers
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - Bus traffic accepted only while select low
// - Select line marks byte command or data
// - One data bit per rising serial clock
// - Bits grouped into eight-bit bytes
// - Most significant bit arrives first
// - Data sampled on first clock edge
// - Pixel is two bytes, 5-6-5 packing
// - Row/column address steps per scan mode
// - Frame memory holds 172800 bytes
// - Backlight lit while its input high
module serial_display_write_port
    import disp_pkg::*;
(
    // System
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // Wishbone slave
    input  wire wb_req_s      wb_req_i,
    output logic              wb_ack_o,
    output logic [31:0]       wb_dat_o,
    // Display pins
    input  wire pin_in_s      pins_i,
    output logic              read_data_out_o,
    output logic              backlight_drive_o
);

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    pin_in_s pin_s;
    logic    sclk_prev;
    logic    sclk_rise;
    logic    sclk_fall;
    logic    selected;

    pin_sync #(
        .WIDTH     ($bits(pin_in_s)),
        .RESET_VAL (PIN_RESET)
    ) u_pin_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   (pins_i),
        .q_o   (pin_s)
    );

    assign sclk_rise = pin_s.serial_clk & ~sclk_prev;
    assign sclk_fall = ~pin_s.serial_clk & sclk_prev;
    assign selected  = ~pin_s.chip_select_n & pin_s.display_reset_n;

    // ------------------------------------------------------------------
    // Byte receiver
    // ------------------------------------------------------------------
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] next_shift_in;
    logic       byte_done;
    logic       next_byte_done;
    logic [7:0] byte_val;
    logic [7:0] next_byte_val;
    logic       byte_dc;
    logic       next_byte_dc;

    always_comb begin
        next_bit_cnt   = bit_cnt;
        next_shift_in  = shift_in;
        next_byte_done = 1'b0;
        next_byte_val  = byte_val;
        next_byte_dc   = byte_dc;
        if (!selected) begin
            next_bit_cnt = 3'h0;
        end else if (sclk_rise) begin
            next_shift_in = {shift_in[6:0], pin_s.write_data_in};
            next_bit_cnt  = bit_cnt + 3'h1;
            if (bit_cnt == BIT_LAST) begin
                next_byte_done = 1'b1;
                next_byte_val  = {shift_in[6:0], pin_s.write_data_in};
                next_byte_dc   = pin_s.data_command_sel;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_prev <= 1'b0;
            bit_cnt   <= 3'h0;
            shift_in  <= 8'h00;
            byte_done <= 1'b0;
            byte_val  <= 8'h00;
            byte_dc   <= 1'b0;
        end else if (ce_i) begin
            sclk_prev <= pin_s.serial_clk;
            bit_cnt   <= next_bit_cnt;
            shift_in  <= next_shift_in;
            byte_done <= next_byte_done;
            byte_val  <= next_byte_val;
            byte_dc   <= next_byte_dc;
        end
    end

    // ------------------------------------------------------------------
    // Pixel addressing, write and read-back
    // ------------------------------------------------------------------
    link_state_e           state;
    link_state_e           next_state;
    logic [COL_W-1:0]      col;
    logic [COL_W-1:0]      next_col;
    logic [ROW_W-1:0]      row;
    logic [ROW_W-1:0]      next_row;
    logic [7:0]            hi_byte;
    logic [7:0]            next_hi_byte;
    logic                  have_hi;
    logic                  next_have_hi;
    logic [7:0]            last_cmd;
    logic [7:0]            next_last_cmd;
    logic [31:0]           pix_count;
    logic [31:0]           next_pix_count;
    pix_wr_s               pix_wr;
    pix_wr_s               next_pix_wr;
    logic [1:0]            rd_wait;
    logic [1:0]            next_rd_wait;
    logic                  rd_first;
    logic                  next_rd_first;
    logic [15:0]           pre_pix;
    logic [15:0]           next_pre_pix;
    logic [15:0]           out_shift;
    logic [15:0]           next_out_shift;
    logic [3:0]            out_cnt;
    logic [3:0]            next_out_cnt;
    logic                  next_rd_bit;
    logic [1:0]            ctrl;
    logic [ADDR_W-1:0]     cur_addr;
    logic [PIXEL_BITS-1:0] rd_data;
    logic [15:0]           rd_pix;
    logic [15:0]           coord;
    logic [ROW_W+COL_W-1:0] stepped;

    function automatic logic [ROW_W+COL_W-1:0] step_addr(
        input logic [ROW_W-1:0] r,
        input logic [COL_W-1:0] c,
        input logic [1:0]       m
    );
        logic             wrap;
        logic [ROW_W-1:0] nr;
        logic [COL_W-1:0] nc;
        nr   = r;
        wrap = m[CTRL_COL_DOWN] ? (c == '0) : (c == COL_LAST);
        if (m[CTRL_COL_DOWN]) begin
            nc = wrap ? COL_LAST : c - COL_W'(1);
        end else begin
            nc = wrap ? '0 : c + COL_W'(1);
        end
        if (wrap && m[CTRL_ROW_DOWN]) begin
            nr = (r == '0) ? ROW_LAST : r - ROW_W'(1);
        end else if (wrap) begin
            nr = (r == ROW_LAST) ? '0 : r + ROW_W'(1);
        end
        return {nr, nc};
    endfunction

    assign cur_addr = ADDR_W'(row) * ADDR_W'(COLS) + ADDR_W'(col);
    assign rd_pix   = {rd_data[17:13], rd_data[11:6], rd_data[5:1]};
    assign coord    = {hi_byte, byte_val};
    assign stepped  = step_addr(row, col, ctrl);

    frame_store u_frame_store (
        .clk_i     (clk_i),
        .ce_i      (ce_i),
        .wr_i      (pix_wr),
        .rd_addr_i (cur_addr),
        .rd_data_o (rd_data)
    );

    always_comb begin
        next_state     = state;
        next_col       = col;
        next_row       = row;
        next_hi_byte   = hi_byte;
        next_have_hi   = have_hi;
        next_last_cmd  = last_cmd;
        next_pix_count = pix_count;
        next_pix_wr    = '0;
        next_rd_wait   = {rd_wait[0], 1'b0};
        next_rd_first  = rd_first;
        next_pre_pix   = pre_pix;
        next_out_shift = out_shift;
        next_out_cnt   = out_cnt;
        next_rd_bit    = read_data_out_o;
        if (!pin_s.display_reset_n) begin
            next_state    = ST_IDLE;
            next_col      = '0;
            next_row      = '0;
            next_have_hi  = 1'b0;
            next_rd_wait  = 2'h0;
            next_rd_first = 1'b0;
        end else if (byte_done && !byte_dc) begin
            next_last_cmd = byte_val;
            next_have_hi  = 1'b0;
            next_rd_first = 1'b0;
            case (byte_val)
                CMD_SET_COLUMN: next_state = ST_COLUMN;
                CMD_SET_ROW:    next_state = ST_ROW;
                CMD_MEM_WRITE:  next_state = ST_WRITE;
                CMD_MEM_READ: begin
                    next_state    = ST_READ;
                    next_rd_first = 1'b1;
                end
                default:        next_state = ST_IDLE;
            endcase
        end else if (byte_done && !have_hi) begin
            next_hi_byte = byte_val;
            next_have_hi = 1'b1;
        end else if (byte_done) begin
            next_have_hi = 1'b0;
            case (state)
                ST_COLUMN: begin
                    next_col   = (coord > 16'(COL_LAST)) ? COL_LAST : coord[COL_W-1:0];
                    next_state = ST_IDLE;
                end
                ST_ROW: begin
                    next_row   = (coord > 16'(ROW_LAST)) ? ROW_LAST : coord[ROW_W-1:0];
                    next_state = ST_IDLE;
                end
                ST_WRITE: begin
                    next_pix_wr.we   = 1'b1;
                    next_pix_wr.addr = cur_addr;
                    next_pix_wr.data = {coord[15:11], coord[15], coord[10:5],
                                        coord[4:0], coord[4]};
                    {next_row, next_col} = stepped;
                    next_pix_count   = pix_count + 32'h1;
                end
                default: ;
            endcase
        end else if (rd_wait[1] && rd_first) begin
            next_rd_bit    = rd_pix[15];
            next_out_shift = {rd_pix[14:0], 1'b0};
            next_out_cnt   = 4'h0;
            next_rd_first  = 1'b0;
            next_rd_wait   = 2'h1;
            {next_row, next_col} = stepped;
        end else if (rd_wait[1]) begin
            next_pre_pix = rd_pix;
        end
        // First fetch waits for the fall that closes the command byte
        if (state == ST_READ && selected && sclk_fall && rd_first && rd_wait == 2'h0) begin
            next_rd_wait = 2'h1;
        end
        // Read-back bits change on falling edges, host samples on rising
        if (state == ST_READ && selected && sclk_fall && !rd_first) begin
            next_out_cnt = out_cnt + 4'h1;
            if (out_cnt == RD_BIT_LAST) begin
                next_rd_bit    = pre_pix[15];
                next_out_shift = {pre_pix[14:0], 1'b0};
                next_rd_wait   = 2'h1;
                {next_row, next_col} = stepped;
            end else begin
                next_rd_bit    = out_shift[15];
                next_out_shift = {out_shift[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state             <= ST_IDLE;
            col               <= '0;
            row               <= '0;
            hi_byte           <= 8'h00;
            have_hi           <= 1'b0;
            last_cmd          <= 8'h00;
            pix_count         <= 32'h0;
            pix_wr            <= '0;
            rd_wait           <= 2'h0;
            rd_first          <= 1'b0;
            pre_pix           <= 16'h0;
            out_shift         <= 16'h0;
            out_cnt           <= 4'h0;
            read_data_out_o   <= 1'b0;
            backlight_drive_o <= 1'b0;
        end else if (ce_i) begin
            state             <= next_state;
            col               <= next_col;
            row               <= next_row;
            hi_byte           <= next_hi_byte;
            have_hi           <= next_have_hi;
            last_cmd          <= next_last_cmd;
            pix_count         <= next_pix_count;
            pix_wr            <= next_pix_wr;
            rd_wait           <= next_rd_wait;
            rd_first          <= next_rd_first;
            pre_pix           <= next_pre_pix;
            out_shift         <= next_out_shift;
            out_cnt           <= next_out_cnt;
            read_data_out_o   <= next_rd_bit;
            backlight_drive_o <= pin_s.backlight_on;
        end
    end

    // ------------------------------------------------------------------
    // Wishbone register slave
    // ------------------------------------------------------------------
    logic        next_ack;
    logic [31:0] next_dat;
    logic [1:0]  next_ctrl;

    always_comb begin
        next_ack  = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
        next_dat  = wb_dat_o;
        next_ctrl = ctrl;
        if (next_ack && wb_req_i.we) begin
            if (wb_req_i.adr == REG_CTRL && wb_req_i.sel[0]) begin
                next_ctrl = wb_req_i.dat[1:0];
            end
        end else if (next_ack) begin
            case (wb_req_i.adr)
                REG_CTRL:      next_dat = {30'h0, ctrl};
                REG_STATUS:    next_dat = {24'h0, have_hi, selected, bit_cnt, state};
                REG_POSITION:  next_dat = {7'h0, row, 8'h00, col};
                REG_LAST_CMD:  next_dat = {24'h0, last_cmd};
                REG_PIX_COUNT: next_dat = pix_count;
                default:       next_dat = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            ctrl     <= CTRL_RESET;
        end else if (ce_i) begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
            ctrl     <= next_ctrl;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_deselect_clears;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !selected |=> bit_cnt == 3'h0;
    endproperty
    a_deselect_clears: assert property (p_deselect_clears)
        else $error("bit count not cleared while deselected");

    property p_command_decode;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && byte_done && !byte_dc && byte_val == CMD_MEM_WRITE
            && pin_s.display_reset_n |=> state == ST_WRITE;
    endproperty
    a_command_decode: assert property (p_command_decode)
        else $error("write command did not enter write state");

    property p_bit_per_rise;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && selected && sclk_rise |=> bit_cnt == $past(bit_cnt) + 3'h1;
    endproperty
    a_bit_per_rise: assert property (p_bit_per_rise)
        else $error("bit count did not advance on rising clock");

    property p_byte_unit;
        @(posedge clk_i) disable iff (rst_i)
        $past(ce_i) && byte_done |-> $past(bit_cnt == BIT_LAST && sclk_rise);
    endproperty
    a_byte_unit: assert property (p_byte_unit)
        else $error("byte completed before eighth bit");

    property p_msb_first;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && selected && sclk_rise
            |=> shift_in == {$past(shift_in[6:0]), $past(pin_s.write_data_in)};
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("bit not shifted in toward the low end");

    property p_sample_on_rise_only;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !sclk_rise |=> shift_in == $past(shift_in);
    endproperty
    a_sample_on_rise_only: assert property (p_sample_on_rise_only)
        else $error("data sampled without a rising clock");

    property p_pixel_pair;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && byte_done && byte_dc && have_hi && state == ST_WRITE
            && pin_s.display_reset_n
            |=> pix_wr.we && pix_wr.data[17:12] == {$past(hi_byte[7:3]), $past(hi_byte[7])};
    endproperty
    a_pixel_pair: assert property (p_pixel_pair)
        else $error("second data byte did not write a pixel");

    property p_column_step;
        @(posedge clk_i) disable iff (rst_i)
        $past(ce_i) && pix_wr.we && !$past(ctrl[CTRL_COL_DOWN]) && $past(col) != COL_LAST
            |-> col == $past(col) + COL_W'(1);
    endproperty
    a_column_step: assert property (p_column_step)
        else $error("column did not step up after pixel write");

    property p_addr_in_frame;
        @(posedge clk_i) disable iff (rst_i)
        pix_wr.we |-> pix_wr.addr < ADDR_W'(PIXELS);
    endproperty
    a_addr_in_frame: assert property (p_addr_in_frame)
        else $error("pixel address outside frame memory");

    property p_backlight;
        @(posedge clk_i) disable iff (rst_i)
        ce_i |=> backlight_drive_o == $past(pin_s.backlight_on);
    endproperty
    a_backlight: assert property (p_backlight)
        else $error("backlight output does not follow its input");

endmodule // serial_display_write_port

// *** verif/host_model.sv ***
// Host-side serial master model driving the display pins
`timescale 1ns/1ps

module host_model
    import disp_pkg::*;
(
    // System
    input  wire logic clk_i,
    // Display pins
    input  wire logic read_data_i,
    output pin_in_s   pins_o
);
    // Read-back bits seen at the rises of the last byte
    logic [7:0] rx = 8'h00;

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    // Reset released, deselected, clock idles low
    initial begin
        pins_o = PIN_RESET;
    end

    // Select or release; released data line shows the inverse of its last level
    task automatic select(input logic on);
        @(posedge clk_i);
        pins_o.chip_select_n <= ~on;
        if (!on) begin
            pins_o.write_data_in <= ~pins_o.write_data_in;
        end
        repeat (4) @(posedge clk_i);
    endtask

    // One byte, 40 ns half period, data set a half period before each rise
    task automatic xfer(input logic dc, input logic [7:0] tx);
        @(posedge clk_i);
        for (int i = 7; i >= 0; i--) begin
            pins_o.write_data_in    <= tx[i];
            pins_o.data_command_sel <= dc;
            pins_o.serial_clk       <= 1'b0;
            repeat (5) @(posedge clk_i);
            pins_o.serial_clk <= 1'b1;
            rx = {rx[6:0], read_data_i};
            repeat (5) @(posedge clk_i);
        end
        pins_o.serial_clk <= 1'b0;
        repeat (5) @(posedge clk_i);
    endtask

    // Reset pulse, then a settling gap before any command
    task automatic pulse_reset();
        @(posedge clk_i);
        pins_o.display_reset_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        pins_o.display_reset_n <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask

    task automatic set_light(input logic on);
        @(posedge clk_i);
        pins_o.backlight_on <= on;
    endtask
endmodule  // host_model

// *** verif/serial_display_write_port_tb.sv ***
// Self-checking bench for the serial display port
`timescale 1ns/1ps

module serial_display_write_port_tb;
    import disp_pkg::*;

    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    wb_req_s     wb_req_i = '0;
    logic        wb_ack_o;
    logic [31:0] wb_dat_o;
    logic        backlight_drive_o;
    logic        read_line;
    pin_in_s     pins;
    int          n_mismatch = 0;
    int          n_compared = 0;

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    serial_display_write_port i_dut (
        .clk_i             (clk_i),
        .rst_i             (rst_i),
        .ce_i              (1'b1),
        .wb_req_i          (wb_req_i),
        .wb_ack_o          (wb_ack_o),
        .wb_dat_o          (wb_dat_o),
        .pins_i            (pins),
        .read_data_out_o   (read_line),
        .backlight_drive_o (backlight_drive_o)
    );

    host_model i_host (
        .clk_i       (clk_i),
        .read_data_i (read_line),
        .pins_o      (pins)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Classic cycle; ack read before this edge's updates land
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        wb_req_i <= '0;
        if (n >= 50) begin
            n_mismatch++;
        end
    endtask

    task automatic rd_check(input string what, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] v;
        wb(1'b0, adr, 32'h0, v);
        check(what, exp, v);
    endtask

    task automatic goto(input logic [8:0] row, input logic [7:0] col);
        i_host.xfer(1'b0, CMD_SET_COLUMN);
        i_host.xfer(1'b1, 8'h00);
        i_host.xfer(1'b1, col);
        i_host.xfer(1'b0, CMD_SET_ROW);
        i_host.xfer(1'b1, {7'h0, row[8]});
        i_host.xfer(1'b1, row[7:0]);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_regs();
        logic [31:0] v;
        wb(1'b1, REG_CTRL, 32'h3, v);
        rd_check("ctrl", REG_CTRL, 32'h3);
        rd_check("unmapped", 8'h14, 32'h0);
        wb(1'b1, REG_CTRL, 32'h0, v);
        rd_check("ctrl cleared", REG_CTRL, 32'h0);
    endtask

    task automatic test_pixels();
        logic [31:0] v;
        i_host.select(1'b1);
        goto(9'd5, 8'd10);
        i_host.xfer(1'b0, CMD_MEM_WRITE);
        i_host.xfer(1'b1, 8'hF8);
        i_host.xfer(1'b1, 8'h1F);
        repeat (4) @(posedge clk_i);
        rd_check("position up", REG_POSITION, {7'h0, 9'd5, 8'h0, 8'd11});
        rd_check("pixels", REG_PIX_COUNT, 32'h1);
        rd_check("last cmd", REG_LAST_CMD, 32'h3);
        wb(1'b1, REG_CTRL, 32'h1, v);
        i_host.xfer(1'b1, 8'h07);
        i_host.xfer(1'b1, 8'hE0);
        repeat (4) @(posedge clk_i);
        rd_check("position down", REG_POSITION, {7'h0, 9'd5, 8'h0, 8'd10});
        rd_check("pixels two", REG_PIX_COUNT, 32'h2);
        wb(1'b1, REG_CTRL, 32'h0, v);
        goto(9'd5, 8'd10);
        i_host.xfer(1'b0, CMD_MEM_READ);
        for (int i = 0; i < 4; i++) begin
            i_host.xfer(1'b1, 8'h00);
            check("read back", (32'hF81F07E0 >> (24 - 8 * i)) & 32'hFF, {24'h0, i_host.rx});
        end
        goto(9'd319, 8'd250);
        repeat (4) @(posedge clk_i);
        rd_check("clamped", REG_POSITION, {7'h0, ROW_LAST, 8'h0, COL_LAST});
        i_host.select(1'b0);
    endtask

    task automatic test_deselect();
        goto(9'd1, 8'd2);
        repeat (4) @(posedge clk_i);
        rd_check("ignored", REG_POSITION, {7'h0, ROW_LAST, 8'h0, COL_LAST});
        rd_check("status", REG_STATUS, 32'h0);
        i_host.select(1'b1);
        i_host.pulse_reset();
        rd_check("host reset", REG_POSITION, 32'h0);
        rd_check("status idle", REG_STATUS, 32'h40);
        rd_check("kept count", REG_PIX_COUNT, 32'h2);
        goto(9'd1, 8'd2);
        repeat (4) @(posedge clk_i);
        rd_check("after reset", REG_POSITION, {7'h0, 9'd1, 8'h0, 8'd2});
        i_host.select(1'b0);
    endtask

    task automatic test_light();
        i_host.set_light(1'b1);
        repeat (6) @(posedge clk_i);
        check("light on", 32'h1, {31'h0, backlight_drive_o});
        i_host.set_light(1'b0);
        repeat (6) @(posedge clk_i);
        check("light off", 32'h0, {31'h0, backlight_drive_o});
    endtask

    task automatic stop_test();
        $display("mismatches %0d, comparisons %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        test_regs();
        test_pixels();
        test_deselect();
        test_light();
        stop_test();
    end

    initial begin
        #300us;
        n_mismatch++;
        stop_test();
    end
endmodule  // serial_display_write_port_tb
